/* File: rtl/ies_map.vh */
// register map, field positions, reset values and timing for ies_top
`ifndef IES_MAP_VH
`define IES_MAP_VH
// register byte addresses
`define IES_ADDR_INT_ENABLE   8'h20
`define IES_ADDR_STATUS       8'h24
`define IES_ADDR_PIN_STATE    8'h28
// enable register fields
`define IES_BIT_DATA_READY_IRQ_ENABLE       7
`define IES_BIT_BUF_EN        6
`define IES_BIT_OT_EN         5
`define IES_BIT_WT_EN         4
`define IES_BIT_ORIENTATION_IRQ_ENABLE     3
`define IES_BIT_AUTO_SLEEP_IRQ_ENABLE       2
`define IES_BIT_BOOT_IRQ_DISABLE      1
`define IES_BIT_WAKE_OUT_EN   0
// source index of data-ready inside the six-wide flag vector
`define IES_DATA_READY_FLAG          5
// enable register reset values, strap low and strap high
`define IES_EN_RST_GND        8'h00
`define IES_EN_RST_VDD        8'h20
// system mode code for wake
`define IES_SYS_MODE_WAKE     2'b01
// clock rate and pulse widths
`define IES_CLK_MHZ           125
`define IES_MOT_PULSE_US      5000
`define IES_BOOT1_PULSE_US    10
`define IES_BOOT2_PULSE_US    1000
`endif

/* File: rtl/ies_top.v */
// interrupt enable gating and interrupt pin signalling of a motion sensor
// Contract
// R1: strap high: pin one pulses low open-drain
// R2: strap high: repeat pulse each data period
// R3: strap high: pin two carries boot only
// R4: enable bits 7..2 gate six sources
// R5: enable reset zero, or bit 5 with strap
// R6: strap low: output read clears ready interrupt
// R7: strap high: ready pulse fixed width, self-ending
// R8: standby ends running ready pulse at once
// R9: enables gate pins only, flags always set
// R10: strap low: bit 1 keeps boot pulse off pins
// R11: strap low: bit 0 shows wake level on pin
`timescale 1ns/1ps
`default_nettype none
`include "ies_map.vh"
module ies_top #(
  parameter integer CNT_W      = 20,
  parameter integer MOT_CYC    = `IES_MOT_PULSE_US * `IES_CLK_MHZ,
  parameter integer BOOT1_CYC  = `IES_BOOT1_PULSE_US * `IES_CLK_MHZ,
  parameter integer BOOT2_CYC  = `IES_BOOT2_PULSE_US * `IES_CLK_MHZ
) (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire        boot_mode_strap,
  input  wire [5:0]  event_set,
  input  wire        out_reg_read,
  input  wire [7:0]  pin_route,
  input  wire        int_pol,
  input  wire [1:0]  sys_mode,
  input  wire        standby,
  input  wire        odr_tick,
  input  wire        boot_done,
  input  wire        irq_pin_one_in,
  output reg         irq_pin_one_out,
  output reg         irq_pin_one_oe,
  input  wire        irq_pin_two_in,
  output reg         irq_pin_two_out,
  output reg         irq_pin_two_oe
);

  // bus pipeline: address phase captured for the data phase
  reg        wr_pend_r;            // write waits for its data phase
  reg  [7:0] wr_addr_r;            // captured write address
  reg  [7:0] en_r;                 // interrupt enable register
  reg  [5:0] flag_r;               // sticky event flags
  reg  [CNT_W-1:0] mot_cnt_r;      // pin one pulse countdown
  reg        mot_drdy_r;           // running pulse is a data-ready one
  reg  [CNT_W-1:0] boot_cnt_r;     // boot pulse countdown
  reg        boot_pin_r;           // boot pulse goes to pin two
  wire       addr_ok;              // address phase accepted
  wire [5:0] flag_clr;             // flag clear requests this cycle
  wire [5:0] src_en;               // enable bits of the six sources
  wire [5:0] live1;                // pending and routed to pin one
  wire [5:0] live2;                // pending and routed to pin two
  wire       drdy_start;           // fresh data-ready pulse wanted
  wire       rep_start;            // periodic repeat pulse wanted
  wire       boot_on;              // boot pulse running
  wire       wake_lvl;             // wake indication, true while awake
  wire       strap_hi;             // strap tied to supply
  reg        p1_act;               // pin one active, push-pull mode
  reg        p2_act;               // pin two active, push-pull mode

  // single zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel & htrans[1] & hready;
  assign strap_hi  = boot_mode_strap;
  assign src_en    = en_r[`IES_BIT_DATA_READY_IRQ_ENABLE:`IES_BIT_AUTO_SLEEP_IRQ_ENABLE]; // [R4]

  // write data phase and read data register
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata    <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_r <= addr_ok & hwrite;
      if (addr_ok)
      begin
        wr_addr_r <= haddr[7:0];
      end
      if (addr_ok & ~hwrite)
      begin
        // read data is ready at the data phase edge
        if (haddr[7:0] == `IES_ADDR_INT_ENABLE)
        begin
          hrdata <= {24'h00_0000, en_r};
        end
        else if (haddr[7:0] == `IES_ADDR_STATUS)
        begin
          hrdata <= {24'h00_0000, flag_r, 1'b0, strap_hi};
        end
        else if (haddr[7:0] == `IES_ADDR_PIN_STATE)
        begin
          hrdata <= {28'h000_0000, irq_pin_two_oe, irq_pin_two_out,
                     irq_pin_one_oe, irq_pin_one_out};
        end
        else
        begin
          // unmapped reads as zero
          hrdata <= 32'h0000_0000;
        end
      end
    end
  end

  // enable register, reset value follows the strap
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      en_r <= strap_hi ? `IES_EN_RST_VDD : `IES_EN_RST_GND; // [R5]
    end
    else if (wr_pend_r && wr_addr_r == `IES_ADDR_INT_ENABLE)
    begin
      en_r <= hwdata[7:0];
    end
  end

  // clear sources: write one to status, or output register read for data-ready
  assign flag_clr[`IES_DATA_READY_FLAG-1:0] =
    (wr_pend_r && wr_addr_r == `IES_ADDR_STATUS) ?
    hwdata[`IES_DATA_READY_FLAG+1:2] : 5'b0_0000;
  assign flag_clr[`IES_DATA_READY_FLAG] =
    out_reg_read | // [R6] [R7]
    (wr_pend_r && wr_addr_r == `IES_ADDR_STATUS &&
     hwdata[`IES_DATA_READY_FLAG+2]);

  // sticky flags, set whatever the enables say, set beats clear
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1)
    begin : g_flag
      always @(posedge ref_clk)
      begin
        if (rst)
        begin
          flag_r[gi] <= 1'b0;
        end
        else if (event_set[gi])
        begin
          flag_r[gi] <= 1'b1; // [R9]
        end
        else if (flag_clr[gi])
        begin
          flag_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // pending sources split by route, a route bit of one picks pin two
  assign live1 = flag_r & src_en & ~pin_route[7:2]; // [R4]
  assign live2 = flag_r & src_en & pin_route[7:2];  // [R4]

  // strap high: fresh data-ready pulse on the event itself
  assign drdy_start = strap_hi & event_set[`IES_DATA_READY_FLAG] &
                      src_en[`IES_DATA_READY_FLAG] &
                      ~pin_route[`IES_BIT_DATA_READY_IRQ_ENABLE]; // [R1]
  // strap high: other pending sources on pin one pulse again each data period
  assign rep_start  = strap_hi & odr_tick &
                      (|live1[`IES_DATA_READY_FLAG-1:0]); // [R2]

  // pin one pulse timer for the strapped mode
  always @(posedge ref_clk)
  begin
    if (rst | ~strap_hi)
    begin
      mot_cnt_r  <= {CNT_W{1'b0}};
      mot_drdy_r <= 1'b0;
    end
    else if (rep_start)
    begin
      // a repeat pulse restarts the width and is not cut by standby
      mot_cnt_r  <= MOT_CYC[CNT_W-1:0]; // [R2]
      mot_drdy_r <= 1'b0;
    end
    else if (drdy_start)
    begin
      mot_cnt_r  <= MOT_CYC[CNT_W-1:0]; // [R7]
      mot_drdy_r <= 1'b1;
    end
    else if (standby && mot_drdy_r)
    begin
      // entering standby cuts a data-ready pulse short
      mot_cnt_r  <= {CNT_W{1'b0}}; // [R8]
      mot_drdy_r <= 1'b0;
    end
    else if (mot_cnt_r != {CNT_W{1'b0}})
    begin
      // pulse ends on its own after the fixed width
      mot_cnt_r <= mot_cnt_r - {{(CNT_W-1){1'b0}}, 1'b1}; // [R7]
      if (mot_cnt_r == {{(CNT_W-1){1'b0}}, 1'b1})
      begin
        mot_drdy_r <= 1'b0;
      end
    end
  end

  // boot completion pulse, width and pin depend on the strap
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      boot_cnt_r <= {CNT_W{1'b0}};
      boot_pin_r <= 1'b0;
    end
    else if (boot_done && strap_hi)
    begin
      // strapped: always on pin two, disable bit ignored
      boot_cnt_r <= BOOT2_CYC[CNT_W-1:0]; // [R3]
      boot_pin_r <= 1'b1;
    end
    else if (boot_done && !en_r[`IES_BIT_BOOT_IRQ_DISABLE])
    begin
      boot_cnt_r <= BOOT1_CYC[CNT_W-1:0]; // [R10]
      boot_pin_r <= pin_route[`IES_BIT_BOOT_IRQ_DISABLE];
    end
    else if (boot_cnt_r != {CNT_W{1'b0}})
    begin
      boot_cnt_r <= boot_cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  assign boot_on  = (boot_cnt_r != {CNT_W{1'b0}});
  assign wake_lvl = (sys_mode == `IES_SYS_MODE_WAKE);

  // push-pull activity of each pin when the strap is low
  always @*
  begin
    p1_act = (|live1) | (boot_on & ~boot_pin_r);
    p2_act = (|live2) | (boot_on & boot_pin_r);
    if (en_r[`IES_BIT_WAKE_OUT_EN])
    begin
      // wake state shown on the selected pin
      if (pin_route[`IES_BIT_WAKE_OUT_EN])
      begin
        p2_act = p2_act | wake_lvl; // [R11]
      end
      else
      begin
        p1_act = p1_act | wake_lvl; // [R11]
      end
    end
  end

  // registered pin drivers
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      irq_pin_one_out <= 1'b0;
      irq_pin_one_oe  <= 1'b0;
      irq_pin_two_out <= 1'b0;
      irq_pin_two_oe  <= 1'b0;
    end
    else if (strap_hi)
    begin
      // open-drain, low while a pulse runs, released otherwise
      irq_pin_one_out <= 1'b0;
      irq_pin_one_oe  <= (mot_cnt_r != {CNT_W{1'b0}}); // [R1]
      irq_pin_two_out <= 1'b0;
      irq_pin_two_oe  <= boot_on & boot_pin_r; // [R3]
    end
    else
    begin
      // push-pull, active level from the polarity input
      irq_pin_one_out <= p1_act ? int_pol : ~int_pol; // [R6]
      irq_pin_one_oe  <= 1'b1;
      irq_pin_two_out <= p2_act ? int_pol : ~int_pol;
      irq_pin_two_oe  <= 1'b1;
    end
  end

endmodule
`default_nettype wire

/* File: test/ies_top_properties.sv */
// bus and interrupt pin assertions for ies_top
`timescale 1ns/1ps
`default_nettype none
module ies_top_chk #(
  parameter int BOOT2_CYC = 125000
) (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic        hready,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        boot_mode_strap,
  input wire logic        standby,
  input wire logic        irq_pin_one_out,
  input wire logic        irq_pin_one_oe,
  input wire logic        irq_pin_two_out,
  input wire logic        irq_pin_two_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [31:0] low2_r; // cycles pin two has been pulled low
  // count the strapped boot pulse length
  always @(posedge ref_clk)
    low2_r <= (rst || !irq_pin_two_oe) ? 0 : low2_r + 1;
  // read address phase taken at an offset
  sequence s_rd(a);
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] == a;
  endsequence
  // strapped pulse starts on either pin
  sequence s_p1;
    boot_mode_strap && $rose(irq_pin_one_oe);
  endsequence
  sequence s_p2;
    boot_mode_strap && $rose(irq_pin_two_oe);
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus wait or error seen");
  a_unmapped_zero: assert property (s_rd(8'h30) |=> hrdata == 0)
    else $error("unmapped read not zero");
  a_strap_status: assert property
    (s_rd(8'h24) |=> hrdata[0] == $past(boot_mode_strap))
    else $error("status strap bit wrong");
  a_pin1_drain: assert property
    (boot_mode_strap && irq_pin_one_oe |-> !irq_pin_one_out)
    else $error("pin one driven high when strapped");
  a_pin1_width: assert property
    (s_p1 |-> (irq_pin_one_oe || standby)[*8])
    else $error("pin one pulse cut short");
  a_pin2_drain: assert property
    (boot_mode_strap && irq_pin_two_oe |-> !irq_pin_two_out)
    else $error("pin two driven high when strapped");
  a_pin2_width: assert property (s_p2 |-> irq_pin_two_oe[*8])
    else $error("pin two pulse cut short");
  a_pin2_ends: assert property
    (boot_mode_strap && irq_pin_two_oe |-> low2_r < BOOT2_CYC)
    else $error("pin two pulse too long");
endmodule
bind ies_top ies_top_chk #(.BOOT2_CYC(BOOT2_CYC)) u_chk (
  .ref_clk(ref_clk),
  .rst(rst),
  .hsel(hsel),
  .hready(hready),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .hrdata(hrdata),
  .boot_mode_strap(boot_mode_strap),
  .standby(standby),
  .irq_pin_one_out(irq_pin_one_out),
  .irq_pin_one_oe(irq_pin_one_oe),
  .irq_pin_two_out(irq_pin_two_out),
  .irq_pin_two_oe(irq_pin_two_oe)
);
`default_nettype wire

/* File: test/ies_host.sv */
// host model: samples one pulled-up pin, counts and times its lows
`timescale 1ns/1ps
`default_nettype none
module ies_host (
  input  wire logic       ref_clk,
  input  wire logic       pin,
  output var  logic [7:0] n_low,
  output var  logic [7:0] w_low
);
  logic       prev_r = 1'b1;  // level at the last edge
  logic [7:0] run_r  = 8'h00; // length of the current low
  initial n_low = 8'h00;
  initial w_low = 8'h00;
  // count falling edges, keep width of the last low
  always @(posedge ref_clk)
  begin
    prev_r <= pin;
    run_r  <= pin ? 8'h00 : run_r + 8'h01;
    if (prev_r && !pin)
      n_low <= n_low + 8'h01;
    if (!prev_r && pin)
      w_low <= run_r;
  end
endmodule
`default_nettype wire

/* File: test/tb_interrupt_enable_signaling.sv */
// self-checking bench of the interrupt enable and pin block
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_enable_signaling;
  localparam int MOT = 20; // shortened pulse widths
  localparam int BT2 = 12;
  logic        ref_clk = 0, rst = 1, hwrite = 0, strap = 0;
  logic        pol = 1, stby = 0, o1, e1, o2, e2, hrdy, hresp;
  logic [1:0]  htrans = 0, sys = 0;
  logic [7:0]  rte = 0, n1, w1, n2, w2, k, j;
  logic [8:0]  pv = 0; // read, boot, tick, six events
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [23:0] rows [5] = '{24'h20ff_ff, 24'h20a5_a5, 24'h205a_5a,
                            24'h2000_00, 24'h30ff_00};
  int          n_mismatch = 0, checks = 0;
  wire         l1 = e1 ? o1 : 1'b1; // pull-up on both pins
  wire         l2 = e2 ? o2 : 1'b1;
  always #4 ref_clk = ~ref_clk;
  ies_top #(.MOT_CYC(MOT), .BOOT1_CYC(8), .BOOT2_CYC(BT2)) dut (
    .ref_clk(ref_clk), .rst(rst), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata),
    .boot_mode_strap(strap), .event_set(pv[5:0]), .out_reg_read(pv[8]),
    .pin_route(rte), .int_pol(pol), .sys_mode(sys), .standby(stby),
    .odr_tick(pv[6]), .boot_done(pv[7]), .irq_pin_one_in(l1),
    .irq_pin_one_out(o1), .irq_pin_one_oe(e1), .irq_pin_two_in(l2),
    .irq_pin_two_out(o2), .irq_pin_two_oe(e2));
  ies_host h1 (.ref_clk(ref_clk), .pin(l1), .n_low(n1), .w_low(w1));
  ies_host h2 (.ref_clk(ref_clk), .pin(l2), .n_low(n2), .w_low(w2));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic run(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // wait for ready with a bound
  task automatic rdy;
    int i;
    i = 0;
    @(posedge ref_clk);
    while (hrdy !== 1'b1)
    begin
      i++;
      if (i > 50)
      begin
        n_mismatch++;
        print_verdict;
      end
      @(posedge ref_clk);
    end
  endtask
  // one single-word transfer, address then data phase
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [31:0] q);
    haddr  <= {24'h0000_00, a};
    hwrite <= w;
    htrans <= 2'h2;
    rdy;
    htrans <= 2'h0;
    hwdata <= {24'h0000_00, d};
    rdy;
    q = hrdata;
  endtask
  task automatic pulse(input logic [8:0] v);
    pv <= v;
    run(1);
    pv <= 9'h000;
  endtask
  task automatic rstb(input logic s);
    strap <= s;
    rst   <= 1'b1;
    run(16);
    rst   <= 1'b0;
    run(1);
  endtask
  initial
  begin
    rstb(1'b0);
    xfer(0, 8'h20, 8'h00, r);
    chk(r, 32'h0000_0000);
    foreach (rows[i])
    begin
      xfer(1, rows[i][23:16], rows[i][15:8], r);
      xfer(0, rows[i][23:16], 8'h00, r);
      chk(r, {24'h0000_00, rows[i][7:0]});
    end
    $display("test register rows done");
    xfer(1, 8'h20, 8'h80, r);
    pulse(9'h020);
    run(3);
    chk(32'(l1), 1);
    pulse(9'h100);
    run(3);
    chk(32'(l1), 0);
    xfer(1, 8'h20, 8'h00, r);
    pulse(9'h020);
    run(3);
    chk(32'(l1), 0);
    xfer(0, 8'h24, 8'h00, r);
    chk(32'(r[7]), 1);
    pulse(9'h080);
    run(2);
    chk(32'(l1), 1);
    run(12);
    xfer(1, 8'h20, 8'h02, r);
    pulse(9'h080);
    run(2);
    chk(32'(l1), 0);
    xfer(1, 8'h20, 8'h01, r);
    sys <= 2'h1;
    run(3);
    chk(32'(l1), 1);
    sys <= 2'h2;
    run(3);
    chk(32'(l1), 0);
    // pending data-ready routed to pin two, active level low
    pol <= 1'b0;
    rte <= 8'h80;
    xfer(1, 8'h20, 8'h80, r);
    run(2);
    chk(32'(l2), 0);
    chk(32'(l1), 1);
    xfer(0, 8'h28, 8'h00, r);
    chk(r, 32'h0000_000b);
    pol <= 1'b1;
    rte <= 8'h00;
    $display("test push-pull done");
    rstb(1'b1);
    xfer(0, 8'h20, 8'h00, r);
    chk(r, 32'h0000_0020);
    xfer(0, 8'h24, 8'h00, r);
    chk(r, 32'h0000_0001);
    xfer(1, 8'h20, 8'h80, r);
    k = n1;
    pulse(9'h020);
    run(MOT + 8);
    chk(32'(n1 - k), 1);
    chk(32'(w1), MOT);
    pulse(9'h020);
    run(6);
    stby <= 1'b1;
    run(3);
    chk(32'(l1), 1);
    stby <= 1'b0;
    pulse(9'h100);
    xfer(1, 8'h20, 8'h08, r);
    pulse(9'h002);
    run(1);
    k = n1;
    repeat (3)
    begin
      pulse(9'h040);
      run(MOT + 10);
    end
    chk(32'(n1 - k), 3);
    xfer(1, 8'h24, 8'h08, r);
    k = n1;
    pulse(9'h040);
    run(MOT + 10);
    chk(32'(n1 - k), 0);
    xfer(1, 8'h20, 8'h20, r);
    rte <= 8'h20;
    pulse(9'h008);
    run(1);
    k = n2;
    j = n1;
    pulse(9'h040);
    run(MOT + 10);
    chk(32'(n2 - k), 0);
    chk(32'(n1 - j), 0);
    pulse(9'h080);
    run(BT2 + 8);
    chk(32'(n2 - k), 1);
    chk(32'(w2), BT2);
    $display("test strapped done");
    print_verdict;
  end
endmodule
`default_nettype wire
